// ==== common/aph_defines.svh ====
`ifndef APH_DEFINES_SVH
`define APH_DEFINES_SVH

// Widths
`define APH_DATA_W 12
`define APH_CFG_W 8
`define APH_CNT_W 8
`define APH_SEQ_W 4
`define APH_AW 5
`define APH_DW 32

// Configuration byte fields
`define APH_PM_MSB 7
`define APH_PM_LSB 6
`define APH_ACQ_BIT 5
`define APH_PM_FULL_DOWN 2'h0
`define APH_PM_STANDBY 2'h1
`define APH_PM_INT_CLK 2'h2
`define APH_PM_EXT_CLK 2'h3

// Reset values
`define APH_CFG_RST 8'h80
`define APH_RESULT_RST 12'h000

// Conversion pacing, in conversion-clock periods or system cycles
`define APH_ACQ_CLKS 3
`define APH_CONV_CLKS 13
`define APH_INT_DIV 2
`define APH_EXT_HALF 2

// Strobe timing, in ns, and derived cycle counts (least times round up)
`define APH_CLK_NS 100
`define APH_T_WR_NS 60
`define APH_T_DO_NS 50
`define APH_CYC_UP(ns) ((((ns) + `APH_CLK_NS - 1) / `APH_CLK_NS))
`define APH_WR_CYC (`APH_CYC_UP(`APH_T_WR_NS))
`define APH_RD_CYC (`APH_CYC_UP(`APH_T_DO_NS) + 1)

// Host register map, byte addresses
`define APH_REG_CONFIG 5'h00
`define APH_REG_COMMAND 5'h04
`define APH_REG_RESULT 5'h08
`define APH_REG_STATUS 5'h0C
`define APH_REG_MASK 5'h10
`define APH_REG_CONTROL 5'h14

// Status, command and control bits
`define APH_ST_W 2
`define APH_ST_DONE 0
`define APH_ST_READ 1
`define APH_ST_BUSY 2
`define APH_CMD_READ 0
`define APH_CTL_AUTO 0

`endif

// ==== common/aph_pkg.sv ====
package aph_pkg;
`include "aph_defines.svh"

typedef enum logic [2:0] {
    DEV_IDLE = 3'h0,
    DEV_ACQ = 3'h1,
    DEV_CONV = 3'h3,
    DEV_FINISH = 3'h2,
    DEV_ACQ_EXT = 3'h6,
    DEV_PWRDN = 3'h4
} aph_dev_state_type;

typedef enum logic [2:0] {
    HST_IDLE = 3'h0,
    HST_WSET = 3'h1,
    HST_WLOW = 3'h3,
    HST_WEND = 3'h2,
    HST_RSET = 3'h4,
    HST_RLOW = 3'h5,
    HST_REND = 3'h7
} aph_host_state_type;

typedef struct packed {
    logic clk_q;
    logic run;
    logic [`APH_CNT_W-1:0] div;
    logic [`APH_CNT_W-1:0] cnt;
} aph_timer_st_type;

typedef struct packed {
    aph_dev_state_type state;
    logic rd_q;
    logic wr_q;
    logic drive;
    logic int_n;
    logic [`APH_CFG_W-1:0] cfg;
    logic [`APH_DATA_W-1:0] hold;
    logic [`APH_DATA_W-1:0] result;
} aph_dev_st_type;

typedef struct packed {
    aph_host_state_type state;
    logic cs_n;
    logic rd_n;
    logic wr_n;
    logic oe;
    logic adc_clk;
    logic int_q;
    logic wait_int;
    logic auto_rd;
    logic [`APH_SEQ_W-1:0] cnt;
    logic [`APH_CNT_W-1:0] clk_div;
    logic [`APH_CFG_W-1:0] cfg;
    logic [`APH_DATA_W-1:0] result;
    logic [`APH_ST_W-1:0] status;
    logic [`APH_ST_W-1:0] mask;
} aph_host_st_type;

endpackage : aph_pkg

// ==== common/aph_if.sv ====
`timescale 1ns/1ns
`include "aph_defines.svh"

interface aph_if;
    logic cs_n;
    logic rd_n;
    logic wr_n;
    logic adc_clk;
    logic int_n;
    logic [`APH_CFG_W-1:0] host_dout;
    logic host_oe;
    logic [`APH_DATA_W-1:0] dev_dout;
    logic dev_oe;
    logic [`APH_DATA_W-1:0] sample_data_bus;

    // Bus level: the device wins while it drives, else the host byte
    assign sample_data_bus = dev_oe ? dev_dout : {4'h0, host_dout};

    modport dev (
        input cs_n, rd_n, wr_n, adc_clk, sample_data_bus,
        output int_n, dev_dout, dev_oe
    );
    modport host (
        output cs_n, rd_n, wr_n, adc_clk, host_dout, host_oe,
        input int_n, sample_data_bus
    );
endinterface : aph_if

// ==== design/aph_conv_timer.sv ====
`timescale 1ns/1ns
`include "aph_defines.svh"

module aph_conv_timer #(
    parameter int INT_DIV = `APH_INT_DIV
) (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic ext_mode_i,
    input wire logic ext_clk_i,
    input wire logic start_i,
    input wire logic [`APH_CNT_W-1:0] len_i,
    output logic tick_o,
    output logic done_o
);
    localparam logic [`APH_CNT_W-1:0] DIV_LAST = `APH_CNT_W'(INT_DIV - 1);

    aph_pkg::aph_timer_st_type st_r;
    aph_pkg::aph_timer_st_type st_nxt;

    // Conversion steps fall on falling edges of the external clock, or on every INT_DIV-th system cycle in internal mode
    assign tick_o = ext_mode_i ? (st_r.clk_q & ~ext_clk_i) : (st_r.div == DIV_LAST);

    // Done ignores start, so a restart in the done cycle forms no loop
    assign done_o = st_r.run && tick_o && (st_r.cnt <= `APH_CNT_W'(1));

    // Count down conversion-clock periods after a start
    always_comb begin
        st_nxt = st_r;
        st_nxt.clk_q = ext_clk_i;
        st_nxt.div = (st_r.div == DIV_LAST) ? '0 : st_r.div + 1'b1;
        if (start_i) begin
            st_nxt.run = 1'b1;
            st_nxt.cnt = len_i;
            st_nxt.div = '0; // Restart the internal period cleanly
        end else if (st_r.run && tick_o) begin
            if (done_o) begin
                st_nxt.run = 1'b0;
            end else begin
                st_nxt.cnt = st_r.cnt - 1'b1;
            end
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end
endmodule : aph_conv_timer

// ==== design/aph_device.sv ====
`timescale 1ns/1ns
`include "aph_defines.svh"

// Overview of operation
// R1 - Done line goes low when result ready
// R2 - Read fall with select low drives result
// R3 - Internal acquisition: write rise latches, starts sequence
// R4 - External acquisition: next write rise starts conversion
// R5 - Host supplies free clock in external mode
// R6 - Host holds clock steady in internal mode
// R7 - Select high keeps data bus released
// R8 - Top two bits choose power and clock
// R9 - Bit five chooses acquisition timing source
// R10 - Read fall returns done line high
// R11 - Host keeps write high past first step
// R12 - Configuration byte travels on low eight lines
module aph_device #(
    parameter int ACQ_CLKS = `APH_ACQ_CLKS,
    parameter int CONV_CLKS = `APH_CONV_CLKS,
    parameter int INT_DIV = `APH_INT_DIV
) (
    input wire logic clock_i,
    input wire logic rst_n_i,
    aph_if.dev link,
    input wire logic [`APH_DATA_W-1:0] sample_i,
    output logic [1:0] power_clock_mode_o,
    output logic acquisition_source_select_o,
    output logic busy_o,
    output logic done_pulse_o
);
    localparam logic [`APH_CNT_W-1:0] ACQ_LEN = `APH_CNT_W'(ACQ_CLKS);
    localparam logic [`APH_CNT_W-1:0] CONV_LEN = `APH_CNT_W'(CONV_CLKS);

    aph_pkg::aph_dev_st_type st_r;
    aph_pkg::aph_dev_st_type st_nxt;

    logic wr_rise;
    logic rd_fall;
    logic [`APH_CFG_W-1:0] new_cfg;
    logic ext_clk_mode;
    logic timer_start;
    logic [`APH_CNT_W-1:0] timer_len;
    logic timer_done;

    // Strobe edges only count while the chip is selected
    assign wr_rise = ~link.cs_n & ~st_r.wr_q & link.wr_n; // R3 R4
    assign rd_fall = ~link.cs_n & st_r.rd_q & ~link.rd_n; // R2 R10

    // Only the low byte of the bus carries configuration
    assign new_cfg = link.sample_data_bus[`APH_CFG_W-1:0]; // R12

    // Only the external-clock code selects external mode; power-down codes select internal
    assign ext_clk_mode = (st_r.cfg[`APH_PM_MSB:`APH_PM_LSB] == `APH_PM_EXT_CLK); // R8

    // One timer paces both self-timed acquisition and conversion
    aph_conv_timer #(
        .INT_DIV(INT_DIV)
    ) u_timer (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .ext_mode_i(ext_clk_mode),
        .ext_clk_i(link.adc_clk),
        .start_i(timer_start),
        .len_i(timer_len),
        .tick_o(),
        .done_o(timer_done)
    );

    // Pin outputs; the enable is combinational so select rising releases at once
    assign link.dev_oe = ~link.cs_n & st_r.drive; // R7
    assign link.dev_dout = st_r.result; // R2
    assign link.int_n = st_r.int_n; // R1

    // User-side status straight from state
    assign power_clock_mode_o = st_r.cfg[`APH_PM_MSB:`APH_PM_LSB];
    assign acquisition_source_select_o = st_r.cfg[`APH_ACQ_BIT];
    assign busy_o = (st_r.state != aph_pkg::DEV_IDLE)
        && (st_r.state != aph_pkg::DEV_PWRDN);
    assign done_pulse_o = (st_r.state == aph_pkg::DEV_FINISH);

    // Next state of the whole device
    always_comb begin
        st_nxt = st_r;
        timer_start = 1'b0;
        timer_len = ACQ_LEN;
        st_nxt.wr_q = link.wr_n;
        st_nxt.rd_q = link.rd_n;

        // Read side: drive from the fall until the strobe or select lifts
        if (rd_fall) begin
            st_nxt.drive = 1'b1; // R2
            st_nxt.int_n = 1'b1; // R10
        end else if (link.rd_n || link.cs_n) begin
            st_nxt.drive = 1'b0;
        end

        // Sequencer; a write during self-timed acquisition or conversion is ignored
        case (st_r.state)
            aph_pkg::DEV_IDLE,
            aph_pkg::DEV_PWRDN: begin
                if (wr_rise) begin
                    st_nxt.cfg = new_cfg; // R3
                    if (!new_cfg[`APH_PM_MSB]) begin
                        // Full and standby power-down both stop here
                        st_nxt.state = aph_pkg::DEV_PWRDN; // R8
                    end else if (new_cfg[`APH_ACQ_BIT]) begin
                        // Track until the host ends acquisition
                        st_nxt.state = aph_pkg::DEV_ACQ_EXT; // R9
                    end else begin
                        st_nxt.state = aph_pkg::DEV_ACQ; // R9
                        timer_start = 1'b1; // R3
                        timer_len = ACQ_LEN;
                    end
                end
            end
            aph_pkg::DEV_ACQ_EXT: begin
                if (wr_rise) begin
                    // Host-timed end of acquisition also loads the new byte
                    st_nxt.cfg = new_cfg; // R12
                    st_nxt.hold = sample_i; // R4
                    st_nxt.state = aph_pkg::DEV_CONV; // R4
                    timer_start = 1'b1;
                    timer_len = CONV_LEN;
                end
            end
            aph_pkg::DEV_ACQ: begin
                if (timer_done) begin
                    // Track/hold closes at the end of acquisition
                    st_nxt.hold = sample_i; // R3
                    st_nxt.state = aph_pkg::DEV_CONV;
                    timer_start = 1'b1;
                    timer_len = CONV_LEN;
                end
            end
            aph_pkg::DEV_CONV: begin
                if (timer_done) begin
                    st_nxt.state = aph_pkg::DEV_FINISH;
                end
            end
            aph_pkg::DEV_FINISH: begin
                // Result and done land together; done beats a same-cycle read fall
                st_nxt.result = st_r.hold; // R1
                st_nxt.int_n = 1'b0; // R1
                st_nxt.state = aph_pkg::DEV_IDLE;
            end
            default: begin
                st_nxt.state = aph_pkg::DEV_IDLE;
            end
        endcase
    end

    // State register; strobes reset to their idle high level
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_r.state <= aph_pkg::DEV_IDLE;
            st_r.rd_q <= 1'b1;
            st_r.wr_q <= 1'b1;
            st_r.drive <= 1'b0;
            st_r.int_n <= 1'b1;
            st_r.cfg <= `APH_CFG_RST;
            st_r.hold <= `APH_RESULT_RST;
            st_r.result <= `APH_RESULT_RST;
        end else begin
            st_r <= st_nxt;
        end
    end
endmodule : aph_device

// ==== design/aph_host.sv ====
// Register access over Avalon-MM and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ns
`include "aph_defines.svh"

module aph_host #(
    parameter int EXT_HALF = `APH_EXT_HALF
) (
    input wire logic clock_i,
    input wire logic rst_n_i,
    aph_if.host link,
    input wire logic [`APH_AW-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [`APH_DW-1:0] avs_writedata,
    output logic [`APH_DW-1:0] avs_readdata,
    output logic avs_waitrequest,
    output logic irq_o
);
    localparam logic [`APH_CNT_W-1:0] HALF_LAST = `APH_CNT_W'(EXT_HALF - 1);
    localparam logic [`APH_SEQ_W-1:0] WR_LEN = `APH_SEQ_W'(`APH_WR_CYC);
    localparam logic [`APH_SEQ_W-1:0] RD_LEN = `APH_SEQ_W'(`APH_RD_CYC);

    aph_pkg::aph_host_st_type st_r;
    aph_pkg::aph_host_st_type st_nxt;

    logic cfg_req;
    logic cmd_req;
    logic idle;
    logic ext_mode;
    logic [`APH_ST_W-1:0] st_set;
    logic [`APH_ST_W-1:0] st_clr;

    assign idle = (st_r.state == aph_pkg::HST_IDLE);
    assign cfg_req = avs_write && (avs_address == `APH_REG_CONFIG);
    assign cmd_req = avs_write && (avs_address == `APH_REG_COMMAND);
    assign ext_mode = (st_r.cfg[`APH_PM_MSB:`APH_PM_LSB] == `APH_PM_EXT_CLK);

    // Link commands stall until the strobe sequencer is free; config writes also stall until a self-timed conversion reports done
    always_comb begin
        avs_waitrequest = 1'b0;
        if (cmd_req && !idle) begin
            avs_waitrequest = 1'b1;
        end
        if (cfg_req && (!idle || st_r.wait_int)) begin
            avs_waitrequest = 1'b1; // R11
        end
    end

    // Register reads answer in the request cycle
    always_comb begin
        avs_readdata = '0;
        case (avs_address)
            `APH_REG_CONFIG: avs_readdata[`APH_CFG_W-1:0] = st_r.cfg;
            `APH_REG_RESULT: avs_readdata[`APH_DATA_W-1:0] = st_r.result;
            `APH_REG_STATUS: begin
                avs_readdata[`APH_ST_W-1:0] = st_r.status;
                avs_readdata[`APH_ST_BUSY] = ~idle | st_r.wait_int;
            end
            `APH_REG_MASK: avs_readdata[`APH_ST_W-1:0] = st_r.mask;
            `APH_REG_CONTROL: avs_readdata[`APH_CTL_AUTO] = st_r.auto_rd;
            default: avs_readdata = '0;
        endcase
        // Idle bus reads as zero
        if (!avs_read) begin
            avs_readdata = '0;
        end
    end

    assign irq_o = |(st_r.status & st_r.mask);
    assign link.cs_n = st_r.cs_n;
    assign link.rd_n = st_r.rd_n;
    assign link.wr_n = st_r.wr_n;
    assign link.host_oe = st_r.oe;
    assign link.host_dout = st_r.cfg; // R12
    assign link.adc_clk = st_r.adc_clk;

    always_comb begin
        st_nxt = st_r;
        st_set = '0;
        st_clr = '0;
        st_nxt.int_q = link.int_n;
        if (!link.int_n) begin
            st_nxt.wait_int = 1'b0; // R11
        end
        st_set[`APH_ST_DONE] = st_r.int_q & ~link.int_n;

        // Free-running clock only while external clock mode is chosen
        if (ext_mode) begin
            st_nxt.clk_div = (st_r.clk_div == HALF_LAST) ? '0 : st_r.clk_div + 1'b1;
            if (st_r.clk_div == HALF_LAST) begin
                st_nxt.adc_clk = ~st_r.adc_clk; // R5
            end
        end else begin
            st_nxt.clk_div = '0;
            st_nxt.adc_clk = 1'b0; // R6
        end

        // Plain register writes
        if (avs_write && avs_address == `APH_REG_STATUS) begin
            st_clr = avs_writedata[`APH_ST_W-1:0];
        end
        if (avs_write && avs_address == `APH_REG_MASK) begin
            st_nxt.mask = avs_writedata[`APH_ST_W-1:0];
        end
        if (avs_write && avs_address == `APH_REG_CONTROL) begin
            st_nxt.auto_rd = avs_writedata[`APH_CTL_AUTO];
        end

        // Strobe sequencer
        case (st_r.state)
            aph_pkg::HST_IDLE: begin
                if (cfg_req && !st_r.wait_int) begin
                    st_nxt.cfg = avs_writedata[`APH_CFG_W-1:0];
                    st_nxt.cs_n = 1'b0;
                    st_nxt.oe = 1'b1; // R12
                    st_nxt.state = aph_pkg::HST_WSET;
                end else if ((cmd_req && avs_writedata[`APH_CMD_READ])
                    || (st_r.auto_rd && !link.int_n)) begin
                    st_nxt.cs_n = 1'b0;
                    st_nxt.state = aph_pkg::HST_RSET;
                end
            end
            aph_pkg::HST_WSET: begin
                st_nxt.wr_n = 1'b0;
                st_nxt.cnt = WR_LEN;
                st_nxt.state = aph_pkg::HST_WLOW;
            end
            aph_pkg::HST_WLOW: begin
                if (st_r.cnt <= `APH_SEQ_W'(1)) begin
                    st_nxt.wr_n = 1'b1; // R4
                    st_nxt.state = aph_pkg::HST_WEND;
                end else begin
                    st_nxt.cnt = st_r.cnt - 1'b1;
                end
            end
            aph_pkg::HST_WEND: begin
                st_nxt.cs_n = 1'b1;
                st_nxt.oe = 1'b0;
                // After a powered self-timed start, no further write until the conversion reports done
                st_nxt.wait_int = st_r.cfg[`APH_PM_MSB] & ~st_r.cfg[`APH_ACQ_BIT]; // R11
                st_nxt.state = aph_pkg::HST_IDLE;
            end
            aph_pkg::HST_RSET: begin
                st_nxt.rd_n = 1'b0; // R2
                st_nxt.cnt = RD_LEN;
                st_nxt.state = aph_pkg::HST_RLOW;
            end
            aph_pkg::HST_RLOW: begin
                if (st_r.cnt <= `APH_SEQ_W'(1)) begin
                    st_nxt.result = link.sample_data_bus; // R2
                    st_nxt.rd_n = 1'b1;
                    st_set[`APH_ST_READ] = 1'b1;
                    st_nxt.state = aph_pkg::HST_REND;
                end else begin
                    st_nxt.cnt = st_r.cnt - 1'b1;
                end
            end
            aph_pkg::HST_REND: begin
                st_nxt.cs_n = 1'b1;
                st_nxt.state = aph_pkg::HST_IDLE;
            end
            default: begin
                st_nxt.state = aph_pkg::HST_IDLE;
            end
        endcase

        // A new event beats a same-cycle clear
        st_nxt.status = (st_r.status & ~st_clr) | st_set;
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_r <= '0;
            st_r.cs_n <= 1'b1;
            st_r.rd_n <= 1'b1;
            st_r.wr_n <= 1'b1;
            st_r.int_q <= 1'b1;
            st_r.cfg <= `APH_CFG_RST;
        end else begin
            st_r <= st_nxt;
        end
    end
endmodule : aph_host

// ==== verif/aph_link_checker.sv ====
`timescale 1ns/1ns
`include "aph_defines.svh"

module aph_link_checker #(
    parameter int ACQ_CLKS = `APH_ACQ_CLKS,
    parameter int CONV_CLKS = `APH_CONV_CLKS,
    parameter int INT_DIV = `APH_INT_DIV
) (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic cs_n,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic adc_clk,
    input wire logic int_n,
    input wire logic [`APH_CFG_W-1:0] host_dout,
    input wire logic host_oe,
    input wire logic [`APH_DATA_W-1:0] dev_dout,
    input wire logic dev_oe
);
    // Done window after a self-timed write; slack covers the tick phase
    localparam int CONV_MIN = (ACQ_CLKS + CONV_CLKS) * INT_DIV - 2;
    localparam int CONV_MAX = CONV_MIN + 10;

    // One clock domain, so one default clock and reset
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);

    // Bus stays released while the part is deselected
    cs_high_release_a: assert property (cs_n |-> !dev_oe)
        else $error("data bus driven while deselected");
    read_drive_a: assert property (!cs_n && $fell(rd_n) |=> dev_oe)
        else $error("read fall did not drive the bus");
    done_release_a: assert property (!cs_n && $fell(rd_n) && !int_n |=> int_n)
        else $error("read fall did not clear done");
    done_hold_a: assert property (!int_n && rd_n |=> !int_n)
        else $error("done dropped without a read");
    drive_stable_a: assert property (dev_oe && $past(dev_oe) |-> $stable(dev_dout))
        else $error("result changed while driven");
    // Byte goes out only inside a selected frame, with no contention
    write_frame_a: assert property (!wr_n |-> !cs_n && host_oe && !dev_oe)
        else $error("write strobe outside a host frame");
    write_hold_a: assert property ($rose(wr_n) && host_dout[7] && !host_dout[5]
        |-> wr_n [*8])
        else $error("write strobe fell too early");
    clock_quiet_a: assert property (host_dout[7:6] != 2'h3
        && $past(host_dout[7:6]) != 2'h3 |-> !adc_clk)
        else $error("clock pin moved in internal clock mode");
    clock_run_a: assert property (host_dout[7:6] == 2'h3
        && $past(host_dout[7:6]) == 2'h3 |-> ##[0:2] $changed(adc_clk))
        else $error("clock pin idle in external clock mode");
    powerdown_quiet_a: assert property ($rose(wr_n) && !cs_n && !host_dout[7] && int_n
        |=> int_n [*8])
        else $error("conversion ran in power-down");
    conv_done_a: assert property ($rose(wr_n) && !cs_n && host_dout[7:5] == 3'h4
        |-> ##[CONV_MIN:CONV_MAX] $fell(int_n))
        else $error("self-timed conversion not done in time");
endmodule : aph_link_checker

// ==== verif/adc_parallel_host_port_tb.sv ====
`timescale 1ns/1ns
`include "aph_defines.svh"

module adc_parallel_host_port_tb;
    logic clock_i, rst_n_i, avs_read, avs_write, avs_waitrequest, irq_o;
    logic [4:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata;
    logic [11:0] sample_i;
    logic [1:0] power_clock_mode_o;
    logic acquisition_source_select_o, busy_o, done_pulse_o;
    int pulses = 0;
    logic [7:0] pd;
    int miscompares = 0;
    int num_checks = 0;
    logic [31:0] exp_q[$];
    string name_q[$];

    aph_if aph_if_inst();
    aph_host aph_host_inst (
        .clock_i(clock_i), .rst_n_i(rst_n_i), .link(aph_if_inst.host),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .irq_o(irq_o));
    aph_device aph_device_inst (
        .clock_i(clock_i), .rst_n_i(rst_n_i), .link(aph_if_inst.dev),
        .sample_i(sample_i), .power_clock_mode_o(power_clock_mode_o),
        .acquisition_source_select_o(acquisition_source_select_o),
        .busy_o(busy_o), .done_pulse_o(done_pulse_o));
    aph_link_checker #(.ACQ_CLKS(`APH_ACQ_CLKS), .CONV_CLKS(`APH_CONV_CLKS),
        .INT_DIV(`APH_INT_DIV)) aph_link_checker_inst (
        .clock_i(clock_i), .rst_n_i(rst_n_i), .cs_n(aph_if_inst.cs_n),
        .rd_n(aph_if_inst.rd_n), .wr_n(aph_if_inst.wr_n), .adc_clk(aph_if_inst.adc_clk),
        .int_n(aph_if_inst.int_n), .host_dout(aph_if_inst.host_dout),
        .host_oe(aph_if_inst.host_oe), .dev_dout(aph_if_inst.dev_dout),
        .dev_oe(aph_if_inst.dev_oe));

    // Free-running system clock, 100 ns period
    initial begin
        clock_i = 1'b0;
        forever #50 clock_i = ~clock_i;
    end

    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : stop_test

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : check

    task automatic timeout(input string what);
        check(what, 32'h0, 32'h1);
        stop_test();
    endtask : timeout

    // One bus cycle; request held until the edge that samples waitrequest low
    task automatic av_cycle(input logic [4:0] a, input logic wr, input logic [31:0] d);
        int n;
        @(posedge clock_i);
        avs_address <= a;
        avs_read <= !wr;
        avs_write <= wr;
        avs_writedata <= d;
        for (n = 0; n < 600; n++) begin
            @(posedge clock_i);
            if (avs_waitrequest === 1'b0) break;
        end
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (n == 600) timeout("waitrequest");
    endtask : av_cycle

    task automatic av_read(input logic [4:0] a, input logic [31:0] exp, input string what);
        exp_q.push_back(exp);
        name_q.push_back(what);
        av_cycle(a, 1'b0, 32'h0);
    endtask : av_read

    // Bounded wait for int_n (sel 0) or cs_n (sel 1) to reach a level
    task automatic wait_pin(input logic sel, input logic lvl);
        int n;
        for (n = 0; n < 600; n++) begin
            @(negedge clock_i);
            if ((sel ? aph_if_inst.cs_n : aph_if_inst.int_n) === lvl) break;
        end
        if (n == 600) timeout("link pin");
    endtask : wait_pin

    // Count done pulses; one is owed per finished conversion
    always @(posedge clock_i) begin
        if (done_pulse_o === 1'b1) begin
            pulses++;
        end
    end

    // Accepted reads are matched at the accepting edge against the oldest note
    always @(posedge clock_i) begin
        if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
            if (exp_q.size() == 0) begin
                timeout("unexpected read");
            end else begin
                check(name_q.pop_front(), avs_readdata, exp_q.pop_front());
            end
        end
    end

    // Full conversion and readout; ext acquisition needs a second write
    task automatic convert(input logic [7:0] cfg, input logic [1:0] msk, input logic auto_rd);
        logic [11:0] smp;
        int p0;
        p0 = pulses;
        smp = 12'($urandom);
        sample_i <= smp;
        av_cycle(`APH_REG_MASK, 1'b1, {30'h0, msk});
        av_cycle(`APH_REG_CONTROL, 1'b1, {31'h0, auto_rd});
        av_cycle(`APH_REG_CONFIG, 1'b1, {24'h0, cfg});
        if (cfg[5]) begin
            repeat (40) @(posedge clock_i);
            check("tracking", 32'(aph_if_inst.int_n), 32'h1);
            smp = 12'($urandom);
            sample_i <= smp;
            av_cycle(`APH_REG_CONFIG, 1'b1, {24'h0, cfg});
        end
        wait_pin(1'b0, 1'b0);
        check("done pulse", 32'(pulses - p0), 32'h1);
        check("power mode", 32'(power_clock_mode_o), 32'(cfg[7:6]));
        check("acq source", 32'(acquisition_source_select_o), 32'(cfg[5]));
        if (!auto_rd) begin
            av_cycle(`APH_REG_COMMAND, 1'b1, 32'h1);
        end
        wait_pin(1'b0, 1'b1);
        wait_pin(1'b1, 1'b1);
        check("irq set", 32'(irq_o), 32'(|msk));
        av_read(`APH_REG_RESULT, 32'(smp), "result");
        av_read(`APH_REG_STATUS, 32'h3, "status");
        av_cycle(`APH_REG_STATUS, 1'b1, 32'h3);
        av_read(`APH_REG_STATUS, 32'h0, "status clear");
        check("irq clear", 32'(irq_o), 32'h0);
    endtask : convert

    initial begin
        rst_n_i = 1'b0;
        avs_address = 5'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        sample_i = 12'h000;
        void'($urandom(19568));
        repeat (2) @(posedge clock_i);
        rst_n_i <= 1'b1;
        // Reset values, unmapped write and read
        av_cycle(5'h1C, 1'b1, 32'hFFFFFFFF);
        av_read(`APH_REG_CONFIG, 32'h80, "config rst");
        av_read(`APH_REG_STATUS, 32'h0, "status rst");
        av_read(`APH_REG_MASK, 32'h0, "mask rst");
        av_read(`APH_REG_RESULT, 32'h0, "result rst");
        av_read(5'h18, 32'h0, "unmapped");
        check("bus idle", 32'(aph_if_inst.dev_oe), 32'h0);
        // Every clock and acquisition mode, masked and unmasked
        convert({3'h4, 5'($urandom)}, 2'h3, 1'b0);
        convert({3'h6, 5'($urandom)}, 2'h0, 1'b0);
        convert({3'h5, 5'($urandom)}, 2'h1, 1'b1);
        convert({3'h7, 5'($urandom)}, 2'h2, 1'b0);
        // Both power-down codes, then a waking write
        for (int i = 0; i < 2; i++) begin
            pd = {1'b0, i[0], 6'($urandom)};
            av_cycle(`APH_REG_CONFIG, 1'b1, {24'h0, pd});
            repeat (60) @(posedge clock_i);
            check("pd mode", 32'(power_clock_mode_o), 32'(pd[7:6]));
            check("pd quiet", 32'(aph_if_inst.int_n), 32'h1);
        end
        convert({3'h4, 5'($urandom)}, 2'h3, 1'b1);
        // Reset in mid-conversion aborts it
        av_cycle(`APH_REG_CONFIG, 1'b1, 32'h80);
        repeat (10) @(posedge clock_i);
        check("busy", 32'(busy_o), 32'h1);
        rst_n_i <= 1'b0;
        repeat (2) @(posedge clock_i);
        check("busy rst", 32'(busy_o), 32'h0);
        check("done rst", 32'(aph_if_inst.int_n), 32'h1);
        rst_n_i <= 1'b1;
        av_read(`APH_REG_CONFIG, 32'h80, "config rst2");
        stop_test();
    end
endmodule : adc_parallel_host_port_tb
